// file: verilog/slave_ctrl.sv
/*
 * Control, event flag, interrupt and low-power logic of a three-address
 * slave with page wrap and write protection of the slave 1 and 2 RAM buffers.
 * Assumes a transfer engine on sys_clk that matches addresses, shifts
 * bytes and reports them here; a power controller drives cpu_halt.
 */
//
// Contract
// - In wait mode the interface works and enabled interrupts reach the CPU.
// - In halt modes registers freeze, interface idles, nothing is acknowledged.
// - Interface resumes after halt wake-up; its own events never wake it.
// - Read and write event interrupts rise only after stop or repeated start.
// - Slaves 1 and 2 share write enable and line; slave 3 separate.
// - Enabled bus or nack error raises line 1 or 2 by slave.
// - Enable bits 3..0 gate read3, read12, write3, write12 interrupts.
// - Page field 7:6 selects 8, 16 or full buffer bytes.
// - Clearing interface enable zeroes page field, interrupt enables, protect bits.
// - Protect bits block master writes to that slave's buffer only.
// - Protected write still acknowledges address and data, loads address.
// - Protected write still increments current address and byte count.
// - Protected write raises no interrupt and sets no lockout flag.
// - Bit 2 of second control register enables the interface.
// - First enabling write sets only enable bit; second write takes rest.
// - Stop or restart after a write sets lockout, suspending the interface.
// - Lockout still set at next address means no acknowledge.
// - Only writing zero or disabling clears lockout; writing one leaves it unchanged.
// - Word mode holds off buffer access; hardware clears it when done.
// - Read and write flags clear on idle status read or disable.
// - Page write wraps the current address within the configured page.
`include "slave_ctrl_params.svh"

module slave_ctrl
    import slave_ctrl_pkg::*;
(
    input wire logic sys_clk,
    input wire logic resetn,
    input wire logic clk_en,
    input wire logic cpu_halt,
    input wire logic scl_pin,
    input wire logic sda_pin,
    input wire logic [2:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata,
    input wire logic addr_seen,
    input wire logic [1:0] addr_slave,
    input wire logic addr_read,
    input wire logic byte_addr_load,
    input wire logic [7:0] byte_addr,
    input wire logic byte_done,
    input wire logic bus_error,
    input wire logic nack_error,
    input wire logic word_done,
    output logic ack_enable,
    output logic ram_write_allow,
    output logic dma_hold,
    output logic [7:0] ram_addr,
    output logic bus_busy,
    output logic irq_line1,
    output logic irq_line2
);
    logic run;
    logic scl_s;
    logic sda_s;
    logic sda_prev_q;
    logic start_det;
    logic stop_det;
    link_state_e state_q;
    slave_id_e slave_q;
    logic read_q;
    logic [7:0] cr1_q;
    logic on_q;
    logic wp1_q;
    logic wp2_q;
    logic lock_q;
    logic word_q;
    logic [7:0] stat_q;
    logic err_l2_q;
    logic [7:0] ca_q [3];
    logic [7:0] count_q;
    logic prot;
    logic finish;
    logic cr1_wr;
    logic cr2_wr;
    logic stat_rd;
    logic addr_take;
    logic [1:0] ca_idx;
    logic [7:0] ca_nxt;

    // Next buffer address: page wrap on writes, full rollover otherwise
    function automatic logic [7:0] next_addr(input logic [7:0] a, input logic [1:0] sel,
                                             input logic s3, input logic rd);
        logic [7:0] keep;
        logic [7:0] r;
        keep = 8'h00;
        if (!rd && sel == `PAGE_8) begin
            keep = `KEEP_PAGE_8;
        end else if (!rd && sel == `PAGE_16) begin
            keep = `KEEP_PAGE_16;
        end
        // Codes 10 and 11 both keep no bits, the full buffer
        r = (a & keep) | (8'(a + 8'h01) & ~keep);
        if (s3) begin
            r = r & `SLAVE3_MASK;
        end
        return r;
    endfunction

    // State advances only while clocked and not halted
    assign run = clk_en && !cpu_halt;

    pin_sync3 u_scl_sync (
        .sys_clk(sys_clk),
        .resetn(resetn),
        .clk_en(clk_en),
        .pin(scl_pin),
        .level(scl_s)
    );

    pin_sync3 u_sda_sync (
        .sys_clk(sys_clk),
        .resetn(resetn),
        .clk_en(clk_en),
        .pin(sda_pin),
        .level(sda_s)
    );

    // Previous data level for condition detection
    always_ff @(posedge sys_clk) begin
        if (!resetn) begin
            sda_prev_q <= 1'b1;
        end else if (clk_en) begin
            sda_prev_q <= sda_s;
        end
    end

    // Start and stop conditions: data moves while clock is high
    assign start_det = run && scl_s && sda_prev_q && !sda_s;
    assign stop_det = run && scl_s && !sda_prev_q && sda_s;

    // Register port decode
    assign cr1_wr = run && reg_wr && reg_addr == `REG_CR1;
    assign cr2_wr = run && reg_wr && reg_addr == `REG_CR2;
    assign stat_rd = run && reg_rd && reg_addr == `REG_STAT;

    // Acknowledge only when enabled, awake and not locked out
    assign ack_enable = on_q && !cpu_halt && !lock_q;
    assign addr_take = run && addr_seen && ack_enable && state_q == LINK_ADDR
                       && addr_slave != SLV_NONE;

    // Protection applies to master writes into slaves 1 and 2 only
    assign prot = !read_q && ((slave_q == SLV_1 && wp1_q) || (slave_q == SLV_2 && wp2_q));

    // A transfer ends on stop or repeated start
    assign finish = (start_det || stop_det) && state_q == LINK_DATA;

    // Buffer writes are dropped when protected or during a word update
    assign ram_write_allow = on_q && !cpu_halt && state_q == LINK_DATA && !read_q
                             && !prot && !word_q;
    assign dma_hold = word_q;
    assign bus_busy = state_q != LINK_IDLE;

    // Bus state tracking
    always_ff @(posedge sys_clk) begin
        if (!resetn) begin
            state_q <= LINK_IDLE;
        end else if (run) begin
            unique case (state_q)
                LINK_IDLE: begin
                    if (start_det) begin
                        state_q <= LINK_ADDR;
                    end
                end
                LINK_ADDR: begin
                    if (stop_det) begin
                        state_q <= LINK_IDLE;
                    end else if (addr_take) begin
                        state_q <= LINK_DATA;
                    end
                end
                LINK_DATA: begin
                    if (stop_det) begin
                        state_q <= LINK_IDLE;
                    end else if (start_det) begin
                        state_q <= LINK_ADDR;
                    end
                end
                default: begin
                    state_q <= LINK_IDLE;
                end
            endcase
        end
    end

    // Selected slave and direction of the current transfer
    always_ff @(posedge sys_clk) begin
        if (!resetn) begin
            slave_q <= SLV_NONE;
            read_q <= 1'b0;
        end else if (addr_take) begin
            slave_q <= slave_id_e'(addr_slave);
            read_q <= addr_read;
        end
    end

    // First control register; zero while the interface is off
    always_ff @(posedge sys_clk) begin
        if (!resetn) begin
            cr1_q <= `REG_RESET;
        end else if (run) begin
            if (!on_q) begin
                cr1_q <= `REG_RESET;
            end else if (cr1_wr) begin
                cr1_q <= reg_wdata & `CR1_MASK;
            end
        end
    end

    // Interface enable; a write while off sets only this bit
    always_ff @(posedge sys_clk) begin
        if (!resetn) begin
            on_q <= 1'b0;
        end else if (cr2_wr) begin
            on_q <= reg_wdata[`ON_BIT];
        end
    end

    // Protect bits, taken only on a write made while already on
    always_ff @(posedge sys_clk) begin
        if (!resetn) begin
            wp1_q <= 1'b0;
            wp2_q <= 1'b0;
        end else if (run) begin
            if (!on_q) begin
                wp1_q <= 1'b0;
                wp2_q <= 1'b0;
            end else if (cr2_wr) begin
                wp1_q <= reg_wdata[`WP1_BIT];
                wp2_q <= reg_wdata[`WP2_BIT];
            end
        end
    end

    // Write lockout: set after an unprotected write, cleared by writing 0
    always_ff @(posedge sys_clk) begin
        if (!resetn) begin
            lock_q <= 1'b0;
        end else if (run) begin
            if (!on_q) begin
                lock_q <= 1'b0;
            end else if (finish && !read_q && !prot) begin
                lock_q <= 1'b1;
            end else if (cr2_wr && !reg_wdata[`LOCK_BIT]) begin
                lock_q <= 1'b0;
            end
        end
    end

    // Word mode: set by software, cleared when the word update completes
    always_ff @(posedge sys_clk) begin
        if (!resetn) begin
            word_q <= 1'b0;
        end else if (run) begin
            if (!on_q) begin
                word_q <= 1'b0;
            end else if (cr2_wr && reg_wdata[`WORD_BIT]) begin
                word_q <= 1'b1;
            end else if (word_done) begin
                word_q <= 1'b0;
            end
        end
    end

    // Event flags: set at transfer end, setting wins over clearing
    always_ff @(posedge sys_clk) begin
        if (!resetn) begin
            stat_q <= `REG_RESET;
        end else if (run) begin
            if (!on_q) begin
                stat_q <= `REG_RESET;
            end else begin
                if (stat_rd) begin
                    stat_q[`NACK_BIT] <= 1'b0;
                    stat_q[`MISPLACED_CONDITION_ERROR_BIT] <= 1'b0;
                end
                if (stat_rd && state_q == LINK_IDLE) begin
                    stat_q[`WF3_BIT:`RF1_BIT] <= 6'h00;
                end
                if (finish && read_q) begin
                    stat_q[`RF1_BIT + slave_q - 1] <= 1'b1;
                end
                if (finish && !read_q && !prot) begin
                    stat_q[`WF1_BIT + slave_q - 1] <= 1'b1;
                end
                if (bus_error) begin
                    stat_q[`MISPLACED_CONDITION_ERROR_BIT] <= 1'b1;
                end
                if (nack_error) begin
                    stat_q[`NACK_BIT] <= 1'b1;
                end
            end
        end
    end

    // Which line an error goes to follows the slave that saw it
    always_ff @(posedge sys_clk) begin
        if (!resetn) begin
            err_l2_q <= 1'b0;
        end else if (run && (bus_error || nack_error)) begin
            err_l2_q <= slave_q == SLV_3;
        end
    end

    // Current address of the active slave and its next value
    assign ca_idx = (slave_q == SLV_NONE) ? 2'h0 : 2'(slave_q - 2'h1);
    assign ca_nxt = next_addr(ca_q[ca_idx], cr1_q[`PAGE_HI:`PAGE_LO],
                              slave_q == SLV_3, read_q);

    // Current addresses; protected writes still load and advance
    always_ff @(posedge sys_clk) begin
        if (!resetn) begin
            for (int i = 0; i < 3; i++) begin
                ca_q[i] <= `REG_RESET;
            end
            ram_addr <= `REG_RESET;
        end else if (run) begin
            if (!on_q) begin
                for (int i = 0; i < 3; i++) begin
                    ca_q[i] <= `REG_RESET;
                end
            end else if (byte_addr_load && state_q == LINK_DATA) begin
                ca_q[ca_idx] <= (slave_q == SLV_3) ? (byte_addr & `SLAVE3_MASK)
                                                   : byte_addr;
                ram_addr <= (slave_q == SLV_3) ? (byte_addr & `SLAVE3_MASK) : byte_addr;
            end else if (byte_done && state_q == LINK_DATA) begin
                ca_q[ca_idx] <= ca_nxt;
                ram_addr <= ca_nxt;
            end
        end
    end

    // Byte count: restarts with each address, counts every byte
    always_ff @(posedge sys_clk) begin
        if (!resetn) begin
            count_q <= `REG_RESET;
        end else if (run) begin
            if (!on_q || addr_take) begin
                count_q <= `REG_RESET;
            end else if (byte_done && state_q == LINK_DATA) begin
                count_q <= 8'(count_q + 8'h01);
            end
        end
    end

    // Read data, valid in the cycle after the read strobe
    always_ff @(posedge sys_clk) begin
        if (!resetn) begin
            reg_rdata <= `REG_RESET;
        end else if (clk_en && reg_rd) begin
            unique case (reg_addr)
                `REG_CR1: reg_rdata <= cr1_q;
                `REG_CR2: reg_rdata <= {3'h0, wp2_q, wp1_q, on_q, lock_q, word_q};
                `REG_STAT: reg_rdata <= stat_q;
                `REG_COUNT: reg_rdata <= count_q;
                `REG_CA1: reg_rdata <= ca_q[0];
                `REG_CA2: reg_rdata <= ca_q[1];
                `REG_CA3: reg_rdata <= ca_q[2];
                default: reg_rdata <= `REG_RESET;
            endcase
        end
    end

    // Interrupt levels; flags are frozen in halt so they wake nothing new
    always_ff @(posedge sys_clk) begin
        if (!resetn) begin
            irq_line1 <= 1'b0;
            irq_line2 <= 1'b0;
        end else if (clk_en) begin
            irq_line1 <= ((stat_q[`WF1_BIT] || stat_q[`WF2_BIT]) && cr1_q[`WR12_EN_BIT])
                || ((stat_q[`RF1_BIT] || stat_q[`RF2_BIT]) && cr1_q[`RD12_EN_BIT])
                || ((stat_q[`MISPLACED_CONDITION_ERROR_BIT] || stat_q[`NACK_BIT]) && cr1_q[`ERR_EN_BIT]
                    && !err_l2_q);
            irq_line2 <= (stat_q[`WF3_BIT] && cr1_q[`WR3_EN_BIT])
                || (stat_q[`RF3_BIT] && cr1_q[`RD3_EN_BIT])
                || ((stat_q[`MISPLACED_CONDITION_ERROR_BIT] || stat_q[`NACK_BIT]) && cr1_q[`ERR_EN_BIT]
                    && err_l2_q);
        end
    end
endmodule

// file: include/slave_ctrl_params.svh
/*
 * Register indices, field positions, reset values and codes of the
 * three-address slave control block.
 * Assumes inclusion by its bare name from a design or bench file.
 */
`ifndef SLAVE_CTRL_PARAMS_SVH
`define SLAVE_CTRL_PARAMS_SVH

// Register indices on the plain register port
`define REG_CR1 3'h0
`define REG_CR2 3'h1
`define REG_STAT 3'h2
`define REG_COUNT 3'h3
`define REG_CA1 3'h4
`define REG_CA2 3'h5
`define REG_CA3 3'h6

// Reset value of every register
`define REG_RESET 8'h00

// Fields of slave_page_irq_control
`define PAGE_HI 7
`define PAGE_LO 6
`define ERR_EN_BIT 4
`define RD3_EN_BIT 3
`define RD12_EN_BIT 2
`define WR3_EN_BIT 1
`define WR12_EN_BIT 0
`define CR1_MASK 8'hDF

// Fields of slave_enable_protect_control
`define WP2_BIT 4
`define WP1_BIT 3
`define ON_BIT 2
`define LOCK_BIT 1
`define WORD_BIT 0

// Fields of the status register
`define NACK_BIT 7
`define MISPLACED_CONDITION_ERROR_BIT 6
`define WF3_BIT 5
`define WF2_BIT 4
`define WF1_BIT 3
`define RF3_BIT 2
`define RF2_BIT 1
`define RF1_BIT 0

// Page length codes and buffer masks
`define PAGE_8 2'h0
`define PAGE_16 2'h1
`define PAGE_FULL 2'h2
`define KEEP_PAGE_8 8'hF8
`define KEEP_PAGE_16 8'hF0
`define SLAVE3_MASK 8'h7F

`endif

// file: include/slave_ctrl_pkg.sv
/*
 * Types shared by the slave control block and its bench.
 * Assumes nothing beyond a SystemVerilog compiler.
 */
package slave_ctrl_pkg;

    // Bus state seen from the start and stop conditions
    typedef enum logic [2:0] {
        LINK_IDLE = 3'b001,
        LINK_ADDR = 3'b010,
        LINK_DATA = 3'b100
    } link_state_e;

    // Slave selected by the address byte
    typedef enum logic [1:0] {
        SLV_NONE = 2'h0,
        SLV_1 = 2'h1,
        SLV_2 = 2'h2,
        SLV_3 = 2'h3
    } slave_id_e;

endpackage

// file: verilog/pin_sync3.sv
/*
 * Three-stage synchroniser for one pin; the output follows once the
 * second and third stages agree.
 * Assumes an asynchronous pin and a clock enable that freezes state.
 */
module pin_sync3 (
    input wire logic sys_clk,
    input wire logic resetn,
    input wire logic clk_en,
    input wire logic pin,
    output logic level
);
    logic s1_q;
    logic s2_q;
    logic s3_q;

    // Three flip-flop chain; only the second stage reads the first
    always_ff @(posedge sys_clk) begin
        if (!resetn) begin
            s1_q <= 1'b1;
            s2_q <= 1'b1;
            s3_q <= 1'b1;
        end else if (clk_en) begin
            s1_q <= pin;
            s2_q <= s1_q;
            s3_q <= s2_q;
        end
    end

    // Accept a new level only when two stages agree
    always_ff @(posedge sys_clk) begin
        if (!resetn) begin
            level <= 1'b1;
        end else if (clk_en && (s2_q == s3_q)) begin
            level <= s3_q;
        end
    end
endmodule

// file: test/i2c_master_model.sv
/*
 * Bus master model that makes start and stop conditions on the pins.
 * Assumes pull-ups, so both lines rest high between frames.
 */
module i2c_master_model (
    output logic scl,
    output logic sda
);
    timeunit 1ns;
    timeprecision 100ps;

    // Lines rest high; the clock stands still outside frames
    initial begin
        scl = 1'b1;
        sda = 1'b1;
    end

    // Data falls while the clock is high, then the clock drops
    task start_cond();
        sda = 1'b0;
        #24;
        scl = 1'b0;
        #24;
    endtask

    // Data rises while the clock is high, then the lines rest
    task stop_cond();
        sda = 1'b0;
        #24;
        scl = 1'b1;
        #24;
        sda = 1'b1;
        #24;
    endtask
endmodule

// file: test/slave_ctrl_sva.sv
/*
 * Concurrent checks on the ports of the slave control block.
 * Assumes one clock domain and register writes accepted only when running.
 */
`include "slave_ctrl_params.svh"

module slave_ctrl_sva (
    input wire logic sys_clk,
    input wire logic resetn,
    input wire logic clk_en,
    input wire logic cpu_halt,
    input wire logic [2:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [7:0] reg_rdata,
    input wire logic addr_seen,
    input wire logic addr_read,
    input wire logic byte_done,
    input wire logic bus_error,
    input wire logic nack_error,
    input wire logic word_done,
    input wire logic ack_enable,
    input wire logic dma_hold,
    input wire logic [7:0] ram_addr,
    input wire logic bus_busy,
    input wire logic irq_line1,
    input wire logic irq_line2
);
    timeunit 1ns;
    timeprecision 100ps;
    logic on_q;
    logic rdir_q;
    logic [1:0] page_q;
    logic [2:0] evt_q;
    logic run;

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!resetn);

    assign run = clk_en && !cpu_halt;

    // Shadow of enable and direction
    always_ff @(posedge sys_clk) begin
        if (!resetn) begin
            on_q <= 1'b0;
            rdir_q <= 1'b0;
        end else if (run) begin
            if (reg_wr && reg_addr == `REG_CR2) on_q <= reg_wdata[`ON_BIT];
            if (addr_seen) rdir_q <= addr_read;
        end
    end

    // Shadow of the page field, cleared while disabled
    always_ff @(posedge sys_clk) begin
        if (!resetn || !on_q) page_q <= 2'h0;
        else if (run && reg_wr && reg_addr == `REG_CR1) page_q <= reg_wdata[7:6];
    end

    // Recent events that may raise a line during a transfer
    always_ff @(posedge sys_clk) begin
        if (!resetn) evt_q <= 3'h0;
        else evt_q <= {evt_q[1:0], bus_error | nack_error | reg_wr};
    end

    a_halt_no_ack: assert property (cpu_halt |-> !ack_enable)
        else $error("ack enabled during halt");
    a_halt_freeze: assert property (cpu_halt |=> $stable(ram_addr) && $stable(dma_hold)
        && $stable(irq_line1) && $stable(irq_line2)) else $error("state moved during halt");
    a_word_clear: assert property (word_done && run && !reg_wr |=> !dma_hold)
        else $error("word mode not cleared");
    a_irq_after_stop: assert property (($rose(irq_line1) || $rose(irq_line2))
        && evt_q == 3'h0 |-> !bus_busy) else $error("event line rose mid transfer");
    a_page_wrap: assert property (byte_done && run && on_q && !rdir_q && page_q == 2'h0
        |=> ram_addr[7:3] == $past(ram_addr[7:3]) && ram_addr[2:0] == $past(ram_addr[2:0]) + 3'h1)
        else $error("page wrap wrong");
    a_cr1_reserved: assert property (reg_rd && clk_en && reg_addr == `REG_CR1
        |=> reg_rdata[5] == 1'b0) else $error("reserved bit read set");
    a_cr2_reserved: assert property (reg_rd && clk_en && reg_addr == `REG_CR2
        |=> reg_rdata[7:5] == 3'h0) else $error("reserved bits read set");
    a_off_no_irq: assert property (!on_q && !$past(on_q) && !$past(on_q, 2)
        |-> !irq_line1 && !irq_line2) else $error("line high while disabled");
endmodule

bind slave_ctrl slave_ctrl_sva slave_ctrl_sva_i (.sys_clk(sys_clk), .resetn(resetn),
    .clk_en(clk_en), .cpu_halt(cpu_halt), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .addr_seen(addr_seen),
    .addr_read(addr_read), .byte_done(byte_done), .bus_error(bus_error),
    .nack_error(nack_error), .word_done(word_done), .ack_enable(ack_enable),
    .dma_hold(dma_hold), .ram_addr(ram_addr), .bus_busy(bus_busy),
    .irq_line1(irq_line1), .irq_line2(irq_line2));

// file: test/slave_ctrl_tb.sv
/*
 * Self-checking bench of the slave control block with a bus master model.
 * Assumes the transfer engine is played by the bench on sys_clk.
 */
`include "slave_ctrl_params.svh"

module slave_ctrl_tb import slave_ctrl_pkg::*; ;
    timeunit 1ns;
    timeprecision 100ps;
    logic sys_clk, resetn, clk_en, cpu_halt, scl_pin, sda_pin, reg_wr, reg_rd;
    logic [2:0] reg_addr;
    logic [7:0] reg_wdata, reg_rdata, byte_addr, ram_addr, v;
    logic addr_seen, addr_read, byte_addr_load, byte_done, bus_error, nack_error, word_done;
    logic [1:0] addr_slave;
    logic ack_enable, ram_write_allow, dma_hold, bus_busy, irq_line1, irq_line2;
    int bad_count, num_checks, cyc, i;

    slave_ctrl slave_ctrl_i (.sys_clk(sys_clk), .resetn(resetn), .clk_en(clk_en),
        .cpu_halt(cpu_halt), .scl_pin(scl_pin), .sda_pin(sda_pin), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .addr_seen(addr_seen), .addr_slave(addr_slave), .addr_read(addr_read),
        .byte_addr_load(byte_addr_load), .byte_addr(byte_addr), .byte_done(byte_done),
        .bus_error(bus_error), .nack_error(nack_error), .word_done(word_done),
        .ack_enable(ack_enable), .ram_write_allow(ram_write_allow), .dma_hold(dma_hold),
        .ram_addr(ram_addr), .bus_busy(bus_busy), .irq_line1(irq_line1), .irq_line2(irq_line2));
    i2c_master_model i2c_master_model_i (.scl(scl_pin), .sda(sda_pin));

    // System clock at 250 MHz
    initial begin
        sys_clk = 1'b0;
        forever #2 sys_clk = ~sys_clk;
    end

    task close_out();
        if (bad_count == 0 && num_checks > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask

    // Hang guard
    always @(posedge sys_clk) begin
        cyc++;
        if (cyc == 30000) begin
            bad_count++;
            close_out();
        end
    end

    task chk(input logic [7:0] got, input logic [7:0] exp);
        num_checks++;
        if (got !== exp) begin
            bad_count++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task wr(input logic [2:0] a, input logic [7:0] d);
        @(posedge sys_clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge sys_clk);
        reg_wr <= 1'b0;
        #1;
    endtask

    task rd_chk(input logic [2:0] a, input logic [7:0] exp);
        @(posedge sys_clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge sys_clk);
        reg_rd <= 1'b0;
        #1 chk(reg_rdata, exp);
    endtask

    // One-cycle engine pulse, by index
    task ev(input int k);
        @(posedge sys_clk);
        case (k)
            0: addr_seen <= 1'b1;
            1: byte_addr_load <= 1'b1;
            2: byte_done <= 1'b1;
            3: bus_error <= 1'b1;
            4: nack_error <= 1'b1;
            default: word_done <= 1'b1;
        endcase
        @(posedge sys_clk);
        {addr_seen, byte_addr_load, byte_done, bus_error, nack_error, word_done} <= 6'h00;
        #1;
    endtask

    task wait_busy(input logic b);
        for (int k = 0; k < 100 && bus_busy !== b; k++) @(posedge sys_clk);
        #1 chk({7'h00, bus_busy}, {7'h00, b});
    endtask

    task frame(input logic go);
        if (go) i2c_master_model_i.start_cond();
        else i2c_master_model_i.stop_cond();
        wait_busy(go);
        repeat (3) @(posedge sys_clk);
        #1;
    endtask

    function automatic logic [7:0] nxt(logic [7:0] a, logic [1:0] pg, logic r, logic s3);
        logic [7:0] keep;
        logic [7:0] n;
        keep = (r || pg[1]) ? 8'h00 : (pg[0] ? `KEEP_PAGE_16 : `KEEP_PAGE_8);
        n = (a & keep) | ((a + 8'h01) & ~keep);
        return s3 ? (n & `SLAVE3_MASK) : n;
    endfunction

    // Whole transfer: address, byte address, n bytes, stop
    task xfer(input logic [1:0] s, input logic r, input logic [7:0] ba, input int n,
              input logic [1:0] pg, input logic wa);
        logic [7:0] a;
        frame(1'b1);
        @(posedge sys_clk);
        addr_slave <= s;
        addr_read <= r;
        byte_addr <= ba;
        ev(0);
        ev(1);
        a = (s == SLV_3) ? (ba & `SLAVE3_MASK) : ba;
        chk(ram_addr, a);
        if (!r) chk({7'h00, ram_write_allow}, {7'h00, wa});
        for (int k = 0; k < n; k++) begin
            ev(2);
            a = nxt(a, pg, r, s == SLV_3);
            chk(ram_addr, a);
        end
        chk({6'h00, irq_line2, irq_line1}, 8'h00);
        frame(1'b0);
        rd_chk(`REG_COUNT, n[7:0]);
    endtask

    // Main sequence
    initial begin
        {resetn, cpu_halt, reg_wr, reg_rd, addr_seen, addr_read, byte_addr_load} = 7'h00;
        {byte_done, bus_error, nack_error, word_done, reg_addr, addr_slave} = 9'h000;
        {reg_wdata, byte_addr} = 16'h0000;
        clk_en = 1'b1;
        {bad_count, num_checks, cyc} = 96'h0;
        void'($urandom(66));
        repeat (2) @(posedge sys_clk);
        resetn <= 1'b1;
        rd_chk(`REG_CR1, `REG_RESET);
        rd_chk(`REG_CR2, `REG_RESET);
        rd_chk(`REG_STAT, `REG_RESET);
        rd_chk(3'h7, 8'h00);
        wr(`REG_CR1, 8'hDF);
        rd_chk(`REG_CR1, 8'h00);
        wr(`REG_CR2, 8'h1F);
        rd_chk(`REG_CR2, 8'h04);
        wr(`REG_CR2, 8'h1F);
        rd_chk(`REG_CR2, 8'h1D);
        chk({7'h00, dma_hold}, 8'h01);
        ev(5);
        rd_chk(`REG_CR2, 8'h1C);
        for (i = 0; i < 6; i++) begin
            v = 8'($urandom);
            wr(`REG_CR1, v);
            rd_chk(`REG_CR1, v & `CR1_MASK);
        end
        wr(`REG_CR1, 8'h01);
        xfer(SLV_1, 1'b0, 8'($urandom), 4, `PAGE_8, 1'b0);
        chk({6'h00, irq_line2, irq_line1}, 8'h00);
        rd_chk(`REG_CR2, 8'h1C);
        wr(`REG_CR2, 8'h06);
        rd_chk(`REG_CR2, 8'h04);
        xfer(SLV_2, 1'b0, 8'h0C, 4, `PAGE_8, 1'b1);
        chk({6'h00, irq_line2, irq_line1}, 8'h01);
        rd_chk(`REG_CR2, 8'h06);
        frame(1'b1);
        chk({7'h00, ack_enable}, 8'h00);
        frame(1'b0);
        rd_chk(`REG_STAT, 8'h10);
        rd_chk(`REG_STAT, 8'h00);
        @(posedge sys_clk);
        #1 chk({6'h00, irq_line2, irq_line1}, 8'h00);
        wr(`REG_CR2, 8'h04);
        chk({7'h00, ack_enable}, 8'h01);
        wr(`REG_CR1, 8'h42);
        xfer(SLV_3, 1'b0, 8'h0E, 3, `PAGE_16, 1'b1);
        chk({6'h00, irq_line2, irq_line1}, 8'h02);
        rd_chk(`REG_STAT, 8'h20);
        wr(`REG_CR2, 8'h04);
        wr(`REG_CR1, 8'hC1);
        xfer(SLV_1, 1'b0, 8'hFE, 3, 2'h3, 1'b1);
        rd_chk(`REG_STAT, 8'h08);
        wr(`REG_CR2, 8'h04);
        wr(`REG_CR1, 8'h04);
        xfer(SLV_1, 1'b1, 8'hFF, 2, `PAGE_8, 1'b0);
        chk({6'h00, irq_line2, irq_line1, ack_enable}, 8'h03);
        rd_chk(`REG_STAT, 8'h01);
        wr(`REG_CR1, 8'h10);
        ev(4);
        ev(3);
        @(posedge sys_clk);
        #1 chk({6'h00, irq_line2, irq_line1}, 8'h01);
        rd_chk(`REG_STAT, 8'hC0);
        @(posedge sys_clk);
        cpu_halt <= 1'b1;
        @(posedge sys_clk);
        #1 chk({7'h00, ack_enable}, 8'h00);
        wr(`REG_CR1, 8'h01);
        @(posedge sys_clk);
        cpu_halt <= 1'b0;
        rd_chk(`REG_CR1, 8'h10);
        chk({7'h00, ack_enable}, 8'h01);
        wr(`REG_CR2, 8'h00);
        rd_chk(`REG_CR1, 8'h00);
        rd_chk(`REG_CR2, 8'h00);
        close_out();
    end
endmodule
